// ### tone_ctrl_map.svh
// Constants for the daisy-chain power tone controller.
`ifndef TONE_CTRL_MAP_SVH
`define TONE_CTRL_MAP_SVH
`define CLK_PERIOD_PS 25000
`define COUPLET_PERIOD_NS 2000
`define WAKE_DETECT_COUNT 4
`define RESUME_DETECT_COUNT 4
`define SHUTDOWN_DETECT_COUNT 8
`define WAKE_SEND_COUNT 6
`define RESUME_SEND_COUNT 6
`define SHUTDOWN_SEND_COUNT 10
`define WAKE_PIN_HIGH_US 30
`define WAKE_PULSE_MIN_LOW_US 100
`define SHUTDOWN_PULSE_LOW_US 2000
`define RX_LOW_RESUME_US 500
`define REG_ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define CTRL_SEND_WAKE 0
`define CTRL_SEND_RESUME 1
`define CTRL_SEND_SHUTDOWN 2
`define CTRL_SOFT_RESET 3
`define CTRL_GO_SLEEP 4
`endif

// ### tone_ctrl_pkg.sv
// Types for the daisy-chain power tone controller.
package tone_ctrl_pkg;
    typedef enum logic [1:0] {
        PWR_SHUTDOWN = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_ACTIVE = 2'b10
    } pwr_mode_t;
    typedef enum logic [1:0] {
        TONE_NONE = 2'b00,
        TONE_WAKE = 2'b01,
        TONE_RESUME = 2'b10,
        TONE_SHUTDOWN = 2'b11
    } tone_kind_t;
    typedef struct packed {
        logic valid;
        logic bit_val;
    } couplet_t;
endpackage : tone_ctrl_pkg

// ### tone_ctrl.sv
// Daisy-chain power tone controller for a stack device.
//
// Notes on behaviour
// - Wake tone: restore defaults, go ACTIVE, forward wake; in every mode.
// - Resume tone in SLEEP: go ACTIVE keeping settings.
// - In SHUTDOWN only wake tones act; others ignored and not forwarded.
// - In SLEEP and ACTIVE wake and resume tones are accepted and forwarded.
// - Shutdown tone accepted in SLEEP or ACTIVE, never forwarded.
// - Shutdown tone enters SHUTDOWN at once.
// - Resume tone in ACTIVE changes nothing but is forwarded.
// - Wake sent on wake rx, wake pin pulse, soft reset, or send bit.
// - Resume sent on resume rx, long receive-line low, or send bit.
// - Requests arriving while a tone is sent are discarded.
// - Shutdown tone sent only by its send bit, to the neighbour only.
// - Shutdown tone leaves chain receiver and transmitter enables alone.
// - Couplets are complementary pairs: wake is one, others zero.
// - All couplets use one fixed couplet period.
// - Receiver counts couplets and declares tones at their thresholds.
// - Wake pin pulse valid after low window then 30us high.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "tone_ctrl_map.svh"
module tone_ctrl
    import tone_ctrl_pkg::*;
#(
    parameter int COUPLET_CYC = (`COUPLET_PERIOD_NS * 1000) / `CLK_PERIOD_PS,
    parameter int WAKE_DET = `WAKE_DETECT_COUNT,
    parameter int RESUME_DET = `RESUME_DETECT_COUNT,
    parameter int SHUTDOWN_DET = `SHUTDOWN_DETECT_COUNT,
    parameter int WAKE_SEND = `WAKE_SEND_COUNT,
    parameter int RESUME_SEND = `RESUME_SEND_COUNT,
    parameter int SHUTDOWN_SEND = `SHUTDOWN_SEND_COUNT,
    parameter int PIN_HIGH_CYC = (`WAKE_PIN_HIGH_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS,
    parameter int PIN_MIN_LOW_CYC = (`WAKE_PULSE_MIN_LOW_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS,
    parameter int PIN_SD_LOW_CYC = (`SHUTDOWN_PULSE_LOW_US * 1000000) / `CLK_PERIOD_PS,
    parameter int RX_LOW_CYC = (`RX_LOW_RESUME_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS
) (
    input wire logic I_CLK, // 40 MHz clock
    input wire logic I_RST, // Synchronous reset, active high
    input wire logic [`REG_ADDR_W-1:0] I_ADDR, // Register address
    input wire logic [7:0] I_WDATA, // Register write data
    input wire logic I_WR, // Write strobe
    input wire logic I_RD, // Read strobe
    output logic [7:0] O_RDATA, // Read data, cycle after strobe
    input wire logic I_LOW_RX_BIT, // Sampled lower chain port line bit
    input wire logic I_LOW_RX_STB, // Lower chain port half-bit strobe
    output logic O_UP_TX_BIT, // Upper chain port line bit
    output logic O_UP_TX_EN, // Upper chain port drive enable
    input wire logic I_WAKE_PIN, // Wake pin level
    input wire logic I_UART_RX, // Serial receive line level
    output logic [1:0] O_MODE, // Power mode
    output logic O_SETTINGS_RST, // Pulse: restore defaults
    output logic O_CHAIN_EN // Chain receiver/transmitter enable
);
    ////////////////////////////////////////////////////////////////////////////
    localparam int CW = 24;
    pwr_mode_t mode_q;
    tone_kind_t rx_tone;
    tone_kind_t tx_kind_q;
    couplet_t cpl;
    logic cpl_break;
    logic [2:0] ctrl_q;
    logic soft_rst_req;
    logic sleep_req;
    logic wake_pin_req, rx_resume_req;
    logic busy;
    logic [CW-1:0] pin_cnt_q, rx_cnt_q;
    logic pin_low_ok_q, pin_phase_q, rx_fired_q;
    logic first_q, have_first_q;
    logic [7:0] ones_q, zeros_q;
    logic [7:0] txn_q;
    logic [CW-1:0] tdiv_q;
    logic thalf_q;
    logic chain_en_q;
    tone_kind_t req;
    logic fwd_wake, fwd_resume;

    ////////////////////////////////////////////////////////////////////////////
    // Register port.
    assign soft_rst_req = I_WR && I_ADDR == `REG_CTRL && I_WDATA[`CTRL_SOFT_RESET];
    assign sleep_req = I_WR && I_ADDR == `REG_CTRL && I_WDATA[`CTRL_GO_SLEEP];
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
        end else if (I_RD) begin
            unique case (I_ADDR)
                `REG_CTRL: O_RDATA <= {5'h00, ctrl_q};
                `REG_STATUS: O_RDATA <= {3'h0, busy, tx_kind_q, mode_q};
                default: O_RDATA <= 8'h00;
            endcase
        end else begin
            O_RDATA <= 8'h00;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST || rx_tone == TONE_WAKE) begin
            ctrl_q <= 3'h0;
        end else begin
            if (I_WR && I_ADDR == `REG_CTRL) begin
                ctrl_q <= I_WDATA[2:0];
            end else begin
                ctrl_q <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake pin pulse
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            pin_cnt_q <= '0;
            pin_low_ok_q <= 1'b0;
            pin_phase_q <= 1'b0;
        end else if (!I_WAKE_PIN) begin
            pin_cnt_q <= pin_phase_q ? pin_cnt_q + 1'b1 : CW'(1);
            pin_phase_q <= 1'b1;
            pin_low_ok_q <= 1'b0;
        end else if (pin_phase_q) begin
            pin_phase_q <= 1'b0;
            pin_low_ok_q <= pin_cnt_q >= CW'(PIN_MIN_LOW_CYC) && pin_cnt_q < CW'(PIN_SD_LOW_CYC);
            pin_cnt_q <= '0;
        end else if (pin_low_ok_q) begin
            pin_cnt_q <= pin_cnt_q + 1'b1;
            if (wake_pin_req) begin
                pin_low_ok_q <= 1'b0;
            end
        end
    end
    assign wake_pin_req = pin_low_ok_q && !pin_phase_q && I_WAKE_PIN && pin_cnt_q == CW'(PIN_HIGH_CYC - 1);

    always_ff @(posedge I_CLK) begin
        if (I_RST || I_UART_RX) begin
            rx_cnt_q <= '0;
            rx_fired_q <= 1'b0;
        end else begin
            if (rx_cnt_q != CW'(RX_LOW_CYC)) begin
                rx_cnt_q <= rx_cnt_q + 1'b1;
            end
            if (rx_resume_req) begin
                rx_fired_q <= 1'b1;
            end
        end
    end
    assign rx_resume_req = !I_UART_RX && !rx_fired_q && rx_cnt_q == CW'(RX_LOW_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // couplet decode: two complementary halves.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            have_first_q <= 1'b0;
            first_q <= 1'b0;
        end else if (I_LOW_RX_STB) begin
            if (have_first_q) begin
                // Equal halves drop the pairing too, so the next tone starts aligned.
                have_first_q <= 1'b0;
            end else begin
                have_first_q <= 1'b1;
                first_q <= I_LOW_RX_BIT;
            end
        end
    end
    assign cpl.valid = I_LOW_RX_STB && have_first_q && first_q != I_LOW_RX_BIT;
    assign cpl.bit_val = first_q;
    assign cpl_break = I_LOW_RX_STB && have_first_q && first_q == I_LOW_RX_BIT;

    always_ff @(posedge I_CLK) begin
        if (I_RST || rx_tone != TONE_NONE) begin
            ones_q <= 8'h00;
            zeros_q <= 8'h00;
        end else if (cpl.valid) begin
            if (cpl.bit_val) begin
                ones_q <= ones_q + 8'h01;
                zeros_q <= 8'h00;
            end else begin
                zeros_q <= zeros_q + 8'h01;
                ones_q <= 8'h00;
            end
        end else if (cpl_break) begin
            // Equal halves end the couplet train; a pending resume is resolved on this strobe.
            ones_q <= 8'h00;
            zeros_q <= 8'h00;
        end
    end

    always_comb begin
        rx_tone = TONE_NONE;
        if (ones_q == 8'(WAKE_DET)) begin
            rx_tone = TONE_WAKE;
        end else if (zeros_q == 8'(SHUTDOWN_DET)) begin
            rx_tone = TONE_SHUTDOWN;
        end else if (zeros_q >= 8'(RESUME_DET) && cpl_break) begin
            rx_tone = TONE_RESUME;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake handling in every mode
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            mode_q <= PWR_ACTIVE;
        end else if (rx_tone == TONE_WAKE || wake_pin_req) begin
            mode_q <= PWR_ACTIVE;
        end else if (mode_q != PWR_SHUTDOWN) begin
            if (rx_tone == TONE_SHUTDOWN) begin
                mode_q <= PWR_SHUTDOWN;
            end else if (rx_tone == TONE_RESUME || rx_resume_req) begin
                mode_q <= PWR_ACTIVE;
            // Software parks an active device in sleep.
            end else if (sleep_req && mode_q == PWR_ACTIVE) begin
                mode_q <= PWR_SLEEP;
            end
        end
    end
    assign O_MODE = mode_q;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_SETTINGS_RST <= 1'b0;
        end else begin
            O_SETTINGS_RST <= rx_tone == TONE_WAKE || wake_pin_req || soft_rst_req;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            chain_en_q <= 1'b1;
        end else begin
            chain_en_q <= chain_en_q;
        end
    end
    assign O_CHAIN_EN = chain_en_q;

    ////////////////////////////////////////////////////////////////////////////
    // shutdown mode only forwards wake
    assign fwd_wake = rx_tone == TONE_WAKE || wake_pin_req || soft_rst_req || ctrl_q[`CTRL_SEND_WAKE];
    assign fwd_resume = mode_q != PWR_SHUTDOWN && (rx_tone == TONE_RESUME || rx_resume_req
        || ctrl_q[`CTRL_SEND_RESUME]);
    // request priority wake, resume, then shutdown; shutdown only from its bit
    always_comb begin
        if (fwd_wake) begin
            req = TONE_WAKE;
        end else if (fwd_resume) begin
            req = TONE_RESUME;
        end else if (ctrl_q[`CTRL_SEND_SHUTDOWN]) begin
            req = TONE_SHUTDOWN;
        end else begin
            req = TONE_NONE;
        end
    end

    assign busy = tx_kind_q != TONE_NONE;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            tx_kind_q <= TONE_NONE;
            txn_q <= 8'h00;
            tdiv_q <= '0;
            thalf_q <= 1'b0;
        end else if (!busy) begin
            tx_kind_q <= req;
            txn_q <= req == TONE_WAKE ? 8'(WAKE_SEND) : req == TONE_RESUME ? 8'(RESUME_SEND) : 8'(SHUTDOWN_SEND);
            tdiv_q <= '0;
            thalf_q <= 1'b0;
        end else if (tdiv_q == CW'(COUPLET_CYC / 2 - 1)) begin
            tdiv_q <= '0;
            thalf_q <= !thalf_q;
            if (thalf_q) begin
                txn_q <= txn_q - 8'h01;
                if (txn_q == 8'h01) begin
                    tx_kind_q <= TONE_NONE;
                end
            end
        end else begin
            tdiv_q <= tdiv_q + 1'b1;
        end
    end

    assign O_UP_TX_EN = busy;
    assign O_UP_TX_BIT = busy && ((tx_kind_q == TONE_WAKE) ^ thalf_q);

    ////////////////////////////////////////////////////////////////////////////
    property p_shutdown_now;
        @(posedge I_CLK) disable iff (I_RST)
        (rx_tone == TONE_SHUTDOWN && mode_q != PWR_SHUTDOWN && !wake_pin_req) |=> mode_q == PWR_SHUTDOWN;
    endproperty
    a_shutdown_now: assert property (p_shutdown_now) else $error("shutdown tone not obeyed");

    property p_wake_active;
        @(posedge I_CLK) disable iff (I_RST)
        rx_tone == TONE_WAKE |=> mode_q == PWR_ACTIVE && O_SETTINGS_RST;
    endproperty
    a_wake_active: assert property (p_wake_active) else $error("wake tone did not activate");

    property p_no_fwd_sd;
        @(posedge I_CLK) disable iff (I_RST)
        (!busy && rx_tone == TONE_SHUTDOWN && !fwd_wake && !ctrl_q[`CTRL_SEND_SHUTDOWN]) |=> tx_kind_q == TONE_NONE;
    endproperty
    a_no_fwd_sd: assert property (p_no_fwd_sd) else $error("shutdown tone forwarded");

    property p_sd_ignore_resume;
        @(posedge I_CLK) disable iff (I_RST)
        (mode_q == PWR_SHUTDOWN && rx_tone == TONE_RESUME && !wake_pin_req) |=> mode_q == PWR_SHUTDOWN;
    endproperty
    a_sd_ignore_resume: assert property (p_sd_ignore_resume) else $error("resume acted in shutdown");

    property p_resume_sleep;
        @(posedge I_CLK) disable iff (I_RST)
        (mode_q == PWR_SLEEP && rx_tone == TONE_RESUME) |=> mode_q == PWR_ACTIVE;
    endproperty
    a_resume_sleep: assert property (p_resume_sleep) else $error("resume did not leave sleep");

    property p_resume_fwd;
        @(posedge I_CLK) disable iff (I_RST)
        (!busy && mode_q == PWR_ACTIVE && rx_tone == TONE_RESUME && !fwd_wake) |=> tx_kind_q == TONE_RESUME;
    endproperty
    a_resume_fwd: assert property (p_resume_fwd) else $error("resume not forwarded");

    property p_busy_hold;
        @(posedge I_CLK) disable iff (I_RST)
        (busy && tdiv_q != CW'(COUPLET_CYC / 2 - 1)) |=> tx_kind_q == $past(tx_kind_q);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("tone changed mid send");

    sequence s_wake_bit;
        I_WR && I_ADDR == `REG_CTRL && I_WDATA[`CTRL_SEND_WAKE] && !busy;
    endsequence
    property p_wake_bit;
        @(posedge I_CLK) disable iff (I_RST)
        s_wake_bit ##1 !busy |=> tx_kind_q == TONE_WAKE ##1 ctrl_q == 3'h0;
    endproperty
    a_wake_bit: assert property (p_wake_bit) else $error("wake bit send failed");

    property p_self_clear;
        @(posedge I_CLK) disable iff (I_RST)
        ctrl_q != 3'h0 && !I_WR |=> ctrl_q == 3'h0;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("send bit stuck");

    property p_encode;
        @(posedge I_CLK) disable iff (I_RST)
        (busy && tx_kind_q == TONE_WAKE && !thalf_q) |-> O_UP_TX_BIT;
    endproperty
    a_encode: assert property (p_encode) else $error("wake couplet not one");
endmodule : tone_ctrl

// ### chain_neighbour.sv
// Behavioural model of the neighbouring stack device on the daisy chain.
`timescale 1ns/100ps
module chain_neighbour #(
    parameter int CYC = 8
) (
    input wire logic i_clk, // Bench clock
    input wire logic i_tx_bit, // Upper chain port line bit from the block
    input wire logic i_tx_en, // Upper chain port drive enable from the block
    output logic o_rx_bit, // Line bit toward the block
    output logic o_rx_stb // Half-bit strobe toward the block
);
    int phase;
    int n_cpl;
    int en_cyc;
    logic first;
    logic last_val;
    logic pair_err;

    initial begin
        o_rx_bit = 1'b0;
        o_rx_stb = 1'b0;
        phase = 0;
        first = 1'b0;
        last_val = 1'b0;
        clear();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decode received couplets
    always @(posedge i_clk) begin
        if (i_tx_en !== 1'b1) begin
            phase <= 0;
        end else begin
            phase <= (phase + 1) % CYC;
            en_cyc <= en_cyc + 1;
            if (phase == CYC / 4) begin
                first <= i_tx_bit;
            end
            if (phase == 3 * CYC / 4) begin
                n_cpl <= n_cpl + 1;
                last_val <= first;
                if (i_tx_bit === first) begin
                    pair_err <= 1'b1;
                end
            end
        end
    end

    task automatic clear();
        n_cpl = 0;
        en_cyc = 0;
        pair_err = 1'b0;
    endtask : clear

    ////////////////////////////////////////////////////////////////////////////////
    // complementary couplets at fixed period
    task automatic send(input logic v, input int n, input int idle);
        for (int i = 0; i < 2 * n + idle; i++) begin
            @(posedge i_clk);
            o_rx_bit <= (i >= 2 * n) ? ~v : (v ^ i[0]);
            o_rx_stb <= 1'b1;
            @(posedge i_clk);
            o_rx_stb <= 1'b0;
            repeat (CYC / 2 - 2) @(posedge i_clk);
        end
        // The released line shows the inverse of its last level.
        o_rx_bit <= v;
    endtask : send
endmodule : chain_neighbour

// ### testbench.sv
// Self-checking testbench for the daisy-chain power tone controller.
`timescale 1ns/100ps
`include "tone_ctrl_map.svh"
module testbench;
    import tone_ctrl_pkg::*;
    localparam int CYC = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wake_pin = 1'b1;
    logic uart_rx = 1'b1;
    logic [7:0] rdata;
    logic rx_bit;
    logic rx_stb;
    logic tx_bit;
    logic tx_en;
    logic [1:0] mode;
    logic settings_rst;
    logic chain_en;
    logic [7:0] d;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int pulses = 0;
    int p;

    always #12.5 clk = ~clk;

    tone_ctrl #(.COUPLET_CYC(CYC), .PIN_HIGH_CYC(4), .PIN_MIN_LOW_CYC(4), .PIN_SD_LOW_CYC(20), .RX_LOW_CYC(10)) uut (
        .I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_LOW_RX_BIT(rx_bit), .I_LOW_RX_STB(rx_stb), .O_UP_TX_BIT(tx_bit), .O_UP_TX_EN(tx_en),
        .I_WAKE_PIN(wake_pin), .I_UART_RX(uart_rx), .O_MODE(mode), .O_SETTINGS_RST(settings_rst),
        .O_CHAIN_EN(chain_en));

    chain_neighbour #(.CYC(CYC)) nb (.i_clk(clk), .i_tx_bit(tx_bit), .i_tx_en(tx_en), .o_rx_bit(rx_bit),
        .o_rx_stb(rx_stb));

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (settings_rst === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : bus_rd

    task automatic expect_tone(input logic v, input int n, input string msg);
        int k;
        k = 0;
        while (tx_en !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1 k++;
        end
        while (tx_en === 1'b1 && k < 600) begin
            @(posedge clk);
            #1 k++;
        end
        check(k < 600 && nb.n_cpl == n && nb.last_val === v && nb.pair_err === 1'b0 && nb.en_cyc == n * CYC, msg);
        nb.clear();
    endtask : expect_tone

    task automatic expect_quiet(input int n, input string msg);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1 seen = seen | (tx_en === 1'b1);
        end
        check(!seen, msg);
    endtask : expect_quiet

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus_rd(`REG_STATUS, d);
        check(d === 8'h02 && chain_en === 1'b1, "reset state");
        bus_rd(4'h5, d);
        check(d === 8'h00, "unmapped read");
    endtask : t_reset

    task automatic t_send_bits();
        bus_wr(`REG_CTRL, 8'h01);
        expect_tone(1'b1, 6, "wake by send bit");
        bus_rd(`REG_CTRL, d);
        check(d === 8'h00, "send bit self-clear");
        bus_wr(`REG_CTRL, 8'h02);
        repeat (3) @(posedge clk);
        bus_wr(`REG_CTRL, 8'h04);
        bus_rd(`REG_STATUS, d);
        check(d === {3'b000, 1'b1, TONE_RESUME, PWR_ACTIVE}, "busy status");
        expect_tone(1'b0, 6, "resume by send bit");
        expect_quiet(150, "discarded request");
        bus_wr(`REG_CTRL, 8'h04);
        expect_tone(1'b0, 10, "shutdown by send bit");
        p = pulses;
        bus_wr(`REG_CTRL, 8'h08);
        expect_tone(1'b1, 6, "wake by soft reset");
        check(pulses == p + 1, "soft reset restores");
    endtask : t_send_bits

    task automatic t_rx_tones();
        p = pulses;
        nb.send(1'b0, 3, 2);
        expect_quiet(100, "short zero run");
        nb.send(1'b0, 5, 2);
        expect_tone(1'b0, 6, "resume forwarded");
        check(mode === PWR_ACTIVE && pulses == p, "resume in active");
        nb.send(1'b0, 8, 2);
        expect_quiet(150, "shutdown not forwarded");
        check(mode === PWR_SHUTDOWN && chain_en === 1'b1, "shutdown entered");
        nb.send(1'b0, 4, 2);
        nb.send(1'b0, 8, 2);
        expect_quiet(150, "ignored in shutdown");
        check(mode === PWR_SHUTDOWN, "still shutdown");
        nb.send(1'b1, 4, 2);
        expect_tone(1'b1, 6, "wake forwarded");
        check(mode === PWR_ACTIVE && pulses == p + 1, "wake restores");
    endtask : t_rx_tones

    task automatic t_pins();
        int lows [3] = '{2, 6, 30};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            wake_pin <= 1'b0;
            repeat (lows[i]) @(posedge clk);
            wake_pin <= 1'b1;
            if (i == 1) begin
                expect_tone(1'b1, 6, "wake pin pulse");
            end else begin
                expect_quiet(100, "pulse out of window");
            end
        end
        @(posedge clk);
        uart_rx <= 1'b0;
        repeat (5) @(posedge clk);
        uart_rx <= 1'b1;
        expect_quiet(60, "short receive low");
        @(posedge clk);
        uart_rx <= 1'b0;
        repeat (12) @(posedge clk);
        uart_rx <= 1'b1;
        expect_tone(1'b0, 6, "resume by receive low");
    endtask : t_pins

    task automatic t_sleep();
        p = pulses;
        bus_wr(`REG_CTRL, 8'h10);
        @(posedge clk);
        #1 check(mode === PWR_SLEEP, "sleep entered");
        nb.send(1'b0, 5, 2);
        expect_tone(1'b0, 6, "resume from sleep");
        check(mode === PWR_ACTIVE && pulses == p, "resume keeps settings");
        bus_wr(`REG_CTRL, 8'h10);
        nb.send(1'b0, 8, 2);
        expect_quiet(150, "sleep shutdown not forwarded");
        check(mode === PWR_SHUTDOWN && chain_en === 1'b1, "shutdown from sleep");
        nb.send(1'b1, 4, 2);
        expect_tone(1'b1, 6, "wake from shutdown");
        bus_wr(`REG_CTRL, 8'h10);
        nb.send(1'b1, 4, 2);
        expect_tone(1'b1, 6, "wake from sleep");
        check(mode === PWR_ACTIVE && pulses == p + 2, "wake from sleep restores");
    endtask : t_sleep

    ////////////////////////////////////////////////////////////////////////////////
    // host waits out each tone, but writes one shutdown request during the resume tone
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_send_bits();
        t_rx_tones();
        t_pins();
        t_sleep();
        print_verdict();
    end
endmodule : testbench
